/* File: hdl/ebrg_pkg.sv */
// package: constants and types for the external bus request/grant block
package ebrg_pkg;
   // ==========================================================
   // synchroniser and arbiter constants
   localparam int SYNC_STAGES = 2;            // flops on each async pin
   localparam logic RST_HALT  = 1'b1;         // core held while in reset
   localparam logic GNT_IDLE  = 1'b1;         // grant pins idle high
   // arbiter states, one-hot
   typedef enum logic [2:0] {
      ST_OWN  = 3'b001,                      // device owns the bus
      ST_WAIT = 3'b010,                      // request seen, access underway
      ST_GNT  = 3'b100                       // bus granted away
   } ebrg_state_t;
endpackage

/* File: hdl/ebrg_sync.sv */
// file: two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module ebrg_sync
   import ebrg_pkg::*;
#(
   parameter logic RST_VAL = 1'b1             // value held under reset
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_ff;                             // first stage, read only by q_out
   // ==========================================================
   // two-stage capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q_out   <= RST_VAL;
      end else begin
         meta_ff <= d_in;
         q_out   <= meta_ff;
      end
   end
endmodule

/* File: hdl/ebrg_top.sv */
// file: bus request/grant hand-over logic for the external memory interface
// Overview of operation
// - idle request: next cycle float bus, grant, halt
// - deferred-halt: keep running until external access needed
// - busy access: grant cycle after access completes
// - grant at access boundaries, between two accesses
// - request withdrawn: drop grant, drive, resume
// - arbitration works during boot and reset
// - grant-hang low when stalled for bus
// - on return drop grant, hang, do access
// - emulator enable selects emulator pins, floats grant
`timescale 1ns/1ps
module ebrg_top
   import ebrg_pkg::*;
(
   input  wire logic REF_CLK,                 // processor clock, 200 MHz
   input  wire logic RST_N,                   // power-on reset, async low
   input  wire logic EXT_BUS_REQUEST_N,       // normal request pin
   input  wire logic EMULATOR_BUS_REQUEST_N,  // emulator request pin
   input  wire logic EXT_RESET_N,             // normal device reset pin
   input  wire logic EMULATOR_RESET_N,        // emulator reset pin
   input  wire logic EMULATOR_ENABLE,         // selects emulator pins
   input  wire logic GO_MODE,                 // deferred-halt enable
   input  wire logic ACCESS_ACTIVE,           // core external access underway
   input  wire logic ACCESS_LAST,             // last cycle of that access
   input  wire logic ACCESS_NEEDED,           // core ready, wants external access
   output logic      EXT_BUS_GRANT_N,         // normal grant pin level
   output logic      EXT_BUS_GRANT_OE,        // normal grant pin drive enable
   output logic      EMULATOR_BUS_GRANT_N,    // emulator grant pin
   output logic      GRANT_HANG_N,            // stalled waiting for bus
   output logic      BUS_DRIVE_OE,            // address/data/strobe drive enable
   output logic      CORE_HALT,               // stall program execution
   output logic      CORE_RESET_N             // selected reset to core
);
   // ==========================================================
   // synchronised pins
   logic req_norm_s;                          // normal request, synced
   logic req_emu_s;                           // emulator request, synced
   logic rst_norm_s;                          // normal reset, synced
   logic rst_emu_s;                           // emulator reset, synced
   logic ee_s;                                // emulator enable, synced
   logic req_act;                             // selected request, active high
   // arbiter state
   ebrg_state_t state_ff;                     // current arbiter state
   ebrg_state_t nxt_state;                    // next arbiter state
   logic        stall;                        // core would need the bus
   logic        grant_nxt;                    // grant asserted next
   ebrg_sync #(.RST_VAL(1'b1)) u_req_norm (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d_in  (EXT_BUS_REQUEST_N),
      .q_out (req_norm_s)
   );
   // emulator copy of the request, same two-flop path
   ebrg_sync #(.RST_VAL(1'b1)) u_req_emu (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d_in  (EMULATOR_BUS_REQUEST_N),
      .q_out (req_emu_s)
   );
   ebrg_sync #(.RST_VAL(1'b0)) u_rst_norm (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d_in  (EXT_RESET_N),
      .q_out (rst_norm_s)
   );
   ebrg_sync #(.RST_VAL(1'b0)) u_rst_emu (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d_in  (EMULATOR_RESET_N),
      .q_out (rst_emu_s)
   );
   ebrg_sync #(.RST_VAL(1'b0)) u_ee (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d_in  (EMULATOR_ENABLE),
      .q_out (ee_s)
   );
   // ==========================================================
   // pin selection
   // emulator pin select
   assign req_act = ee_s ? !req_emu_s : !req_norm_s;
   // ==========================================================
   // next-state decision
   // deferred halt stall
   assign stall = GO_MODE ? ACCESS_NEEDED : 1'b1;
   // arbiter next state from the selected, synced request
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OWN: begin
            // last cycle of an access is a boundary too
            if (req_act && (!ACCESS_ACTIVE || ACCESS_LAST)) begin
               nxt_state = ST_GNT;
            end else if (req_act) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // access boundary grant
            // withdrawn before the boundary: keep the bus
            if (!req_act) begin
               nxt_state = ST_OWN;
            end else if (ACCESS_LAST || !ACCESS_ACTIVE) begin
               nxt_state = ST_GNT;
            end
         end
         ST_GNT: begin
            if (!req_act) begin
               nxt_state = ST_OWN;
            end
         end
         default: nxt_state = ST_OWN;
      endcase
   end
   assign grant_nxt = (nxt_state == ST_GNT);
   // ==========================================================
   // state register, independent of core reset
   // arbitration during reset
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff <= ST_OWN;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // ==========================================================
   // grant pins and bus drivers
   // all pin levels registered, none straight from logic
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         EXT_BUS_GRANT_N      <= GNT_IDLE;
         EXT_BUS_GRANT_OE     <= 1'b1;
         EMULATOR_BUS_GRANT_N <= GNT_IDLE;
         BUS_DRIVE_OE         <= 1'b1;
      end else begin
         EXT_BUS_GRANT_OE     <= !ee_s;
         EXT_BUS_GRANT_N      <= !(grant_nxt && !ee_s);
         EMULATOR_BUS_GRANT_N <= !(grant_nxt && ee_s);
         BUS_DRIVE_OE         <= !grant_nxt;
      end
   end
   // ==========================================================
   // halt and grant-hang
   // both share one process so they move on the same edge
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_HALT    <= RST_HALT;
         GRANT_HANG_N <= 1'b1;
      end else begin
         CORE_HALT    <= grant_nxt && stall;
         GRANT_HANG_N <= !(grant_nxt && ACCESS_NEEDED);
      end
   end
   // core reset from the selected pin
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_RESET_N <= 1'b0;
      end else begin
         CORE_RESET_N <= ee_s ? rst_emu_s : rst_norm_s;
      end
   end
   // ==========================================================
   // checks
   // all sample on the processor clock, off under power reset
   a_idle_grant_next: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_OWN && req_act && !ACCESS_ACTIVE) |=> !BUS_DRIVE_OE)
      else $error("bus not floated after idle request");
   a_busy_no_grant: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_OWN && req_act && ACCESS_ACTIVE && !ACCESS_LAST) |=> BUS_DRIVE_OE)
      else $error("bus granted during access");
   a_boundary_grant: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_WAIT && req_act && ACCESS_LAST) |=> state_ff == ST_GNT)
      else $error("no grant at access boundary");
   a_release_resume: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_GNT && !req_act) |=> (BUS_DRIVE_OE && !CORE_HALT))
      else $error("no resume after request withdrawn");
   a_go_mode_runs: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (GO_MODE && !ACCESS_NEEDED) |=> !CORE_HALT)
      else $error("halted in deferred mode without need");
   a_hang_cause: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !GRANT_HANG_N |-> $past(grant_nxt && ACCESS_NEEDED))
      else $error("grant hang without cause");
   a_return_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_GNT && !req_act) |=> (GRANT_HANG_N && EXT_BUS_GRANT_N))
      else $error("grant or hang held after return");
   a_emu_grant_float: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ee_s |=> (!EXT_BUS_GRANT_OE && EXT_BUS_GRANT_N))
      else $error("normal grant driven in emulation");
   a_grant_in_reset: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (!CORE_RESET_N && state_ff == ST_OWN && req_act && !ACCESS_ACTIVE && !ee_s)
      |=> !EXT_BUS_GRANT_N)
      else $error("no grant while core reset");
   a_sync_latency: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ($fell(EXT_BUS_REQUEST_N) && !ee_s && !ACCESS_ACTIVE && state_ff == ST_OWN)
      |-> ##1 EXT_BUS_GRANT_N)
      else $error("request used before synchronisation");
   a_last_cycle_grant: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state_ff == ST_OWN && req_act && ACCESS_LAST) |=> !BUS_DRIVE_OE)
      else $error("no grant after last access cycle");
   a_go_halt_need: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (GO_MODE && ACCESS_NEEDED && state_ff == ST_GNT && req_act) |=> CORE_HALT)
      else $error("deferred mode did not stall on access");
   a_emu_req_ignored: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (ee_s && state_ff == ST_OWN && !req_norm_s && req_emu_s)
      |=> BUS_DRIVE_OE)
      else $error("normal request honoured in emulation");
   a_oe_normal: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !ee_s |=> EXT_BUS_GRANT_OE)
      else $error("normal grant floated outside emulation");
endmodule

/* File: tb/ebrg_master_model.sv */
// file: behavioural outside bus master that asks for the memory bus
`timescale 1ns/1ps
module ebrg_master_model (
   input  wire logic clk,      // processor clock
   input  wire logic want,     // bench asks this master to take the bus
   input  wire logic yield_en, // hand bus back when device stalls
   input  wire logic hang_n,   // device stalled waiting for the bus
   output logic      req_n     // request pin, low asks for the bus
);
   // =====
   // request pin, moved only just after falling edges
   logic req_ff     = 1'b1;  // registered request level
   logic yielded_ff = 1'b0;  // bus handed back, stay off until want drops
   assign req_n = req_ff;
   always @(negedge clk) begin
      if (!want) begin
         yielded_ff <= 1'b0;
      end else if (yield_en && !hang_n) begin
         yielded_ff <= 1'b1;
      end
      req_ff <= !(want && !yielded_ff && !(yield_en && !hang_n));
   end
endmodule

/* File: tb/ebrg_tb_top.sv */
// file: self-checking bench for the bus request/grant block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %s exp %0b got %0b", n, e, a); end end
module ebrg_tb_top;
   import ebrg_pkg::*;
   // =====
   // stimulus and observed signals
   logic ref_clk = 0, rst_n = 0, want = 0, yld = 0, go = 0, act = 0, last = 0, need = 0;
   logic emu_req_n = 1, ext_rst_n = 1, emu_rst_n = 1, emu_en = 0, req_n;
   logic gnt_n, gnt_oe, emu_gnt_n, hang_n, drv_oe, halt, core_rst_n;
   int   err_count = 0, checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   ebrg_master_model mst (.clk(ref_clk), .want(want), .yield_en(yld), .hang_n(hang_n),
      .req_n(req_n));
   ebrg_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .EXT_BUS_REQUEST_N(req_n),
      .EMULATOR_BUS_REQUEST_N(emu_req_n), .EXT_RESET_N(ext_rst_n),
      .EMULATOR_RESET_N(emu_rst_n), .EMULATOR_ENABLE(emu_en), .GO_MODE(go),
      .ACCESS_ACTIVE(act), .ACCESS_LAST(last), .ACCESS_NEEDED(need),
      .EXT_BUS_GRANT_N(gnt_n), .EXT_BUS_GRANT_OE(gnt_oe), .EMULATOR_BUS_GRANT_N(emu_gnt_n),
      .GRANT_HANG_N(hang_n), .BUS_DRIVE_OE(drv_oe), .CORE_HALT(halt),
      .CORE_RESET_N(core_rst_n));
   // =====
   // timing helpers: drive at falling edge, look just after rising edge
   task ne(int n); repeat (n) @(negedge ref_clk); endtask
   task pe(int n); repeat (n) @(posedge ref_clk); #1; endtask
   // idle grant, then release
   task t_idle;
      ne(1); want <= 1; @(negedge req_n); pe(1);
      `CHK("gnt_early", 1'b1, gnt_n)
      pe(1);
      `CHK("gnt_sync", 1'b1, gnt_n)
      pe(1);
      `CHK("gnt", 1'b0, gnt_n)
      `CHK("oe_norm", 1'b1, gnt_oe)
      `CHK("drv_oe", 1'b0, drv_oe)
      `CHK("halt", 1'b1, halt)
      ne(1); want <= 0; @(posedge req_n); pe(4);
      `CHK("gnt_rel", 1'b1, gnt_n)
      `CHK("drv_rel", 1'b1, drv_oe)
      `CHK("halt_rel", 1'b0, halt)
   endtask
   // request during an access, granted at the access boundary
   task t_busy;
      ne(1); act <= 1; want <= 1; @(negedge req_n); pe(6);
      `CHK("gnt_busy", 1'b1, gnt_n)
      ne(1); last <= 1; ne(1); last <= 0; act <= 0; pe(2);
      `CHK("gnt_bound", 1'b0, gnt_n)
      `CHK("drv_bound", 1'b0, drv_oe)
      ne(1); want <= 0; pe(6);
      `CHK("drv_busy_rel", 1'b1, drv_oe)
      `CHK("gnt_busy_rel", 1'b1, gnt_n)
   endtask
   // request first seen in an access's last cycle, second access right behind it
   task t_split;
      ne(1); act <= 1; want <= 1; @(negedge req_n); ne(2); last <= 1; ne(1); last <= 0; pe(1);
      `CHK("gnt_split", 1'b0, gnt_n)
      `CHK("halt_split", 1'b1, halt)
      ne(1); want <= 0; act <= 0; pe(6);
      `CHK("drv_split_rel", 1'b1, drv_oe)
   endtask
   // deferred halt, stall, master yields on hang
   task t_go;
      ne(1); go <= 1; yld <= 1; want <= 1; @(negedge req_n); pe(3);
      `CHK("gnt_go", 1'b0, gnt_n)
      `CHK("halt_go", 1'b0, halt)
      `CHK("hang_idle", 1'b1, hang_n)
      ne(1); need <= 1; @(posedge req_n); #1;
      `CHK("halt_need", 1'b1, halt)
      `CHK("hang_on", 1'b0, hang_n)
      `CHK("gnt_held", 1'b0, gnt_n)
      pe(3);
      `CHK("gnt_back", 1'b1, gnt_n)
      `CHK("hang_off", 1'b1, hang_n)
      `CHK("halt_off", 1'b0, halt)
      ne(1); want <= 0; need <= 0; go <= 0; yld <= 0; pe(6);
   endtask
   // emulator pins take over
   task t_emu;
      ne(1); emu_en <= 1; emu_rst_n <= 0; want <= 1; pe(5);
      `CHK("oe_emu", 1'b0, gnt_oe)
      `CHK("rst_emu", 1'b0, core_rst_n)
      `CHK("drv_ign", 1'b1, drv_oe)
      ne(1); emu_rst_n <= 1; emu_req_n <= 0; pe(4);
      `CHK("emu_gnt", 1'b0, emu_gnt_n)
      `CHK("gnt_norm_emu", 1'b1, gnt_n)
      `CHK("rst_emu_rel", 1'b1, core_rst_n)
      ne(1); emu_req_n <= 1; want <= 0; pe(4);
      `CHK("emu_rel", 1'b1, emu_gnt_n)
      ne(1); emu_en <= 0; pe(4);
      `CHK("oe_back", 1'b1, gnt_oe)
   endtask
   // closing verdict
   task end_of_test;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // =====
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      ne(1); rst_n <= 1; pe(2);
      t_idle;
      t_busy;
      t_split;
      t_go;
      ne(1); ext_rst_n <= 0; pe(4);
      `CHK("core_rst", 1'b0, core_rst_n)
      t_idle; // arbitration under device reset
      ne(1); ext_rst_n <= 1;
      t_emu;
      end_of_test;
   end
   // watchdog against a hang
   initial begin
      #20000;
      err_count++;
      end_of_test;
   end
endmodule
